// ### ubm_pkg.sv
/*
 * package for the endpoint buffer manager: register offsets, field
 * positions, reset values, transfer types and timing figures.
 * assumes nothing beyond a SystemVerilog tool.
 */
package ubm_pkg;

	// ----------------------------------------------------------------
	// sizes
	// ----------------------------------------------------------------
	localparam int NUM_EP = 4;
	localparam int EP_W = 2;
	localparam int OFS_W = 7;           // byte position inside a page
	localparam int PAGE_BYTES = 128;
	localparam int MEM_AW = 8;          // page bit plus byte position
	localparam logic [6:0] CTRL_DEF_LEN = 7'h08;
	localparam logic [6:0] MAX_PKT_LEN = 7'h40;

	// ----------------------------------------------------------------
	// register offsets (8-bit address)
	// ----------------------------------------------------------------
	localparam logic [7:0] ADDR_SEL = 8'h00;     // endpoint select
	localparam logic [7:0] ADDR_OFFSET = 8'h01;  // buffer_offset_reg
	localparam logic [7:0] ADDR_DATA = 8'h02;    // buffer_data_reg
	localparam logic [7:0] ADDR_CTRL = 8'h03;    // endpoint_control_reg
	localparam logic [7:0] ADDR_LEN = 8'h04;     // endpoint_length_reg
	localparam logic [7:0] ADDR_STAT = 8'h05;    // endpoint status

	// ----------------------------------------------------------------
	// endpoint_control_reg fields
	// ----------------------------------------------------------------
	localparam int CTL_TYPE_LSB = 0;    // two bits: transfer type
	localparam int CTL_DIR_IN = 2;      // 1: device to host
	localparam int CTL_DUAL = 3;        // 1: dual buffer mode
	localparam int CTL_PAGE = 4;        // single mode page
	localparam int CTL_INC = 5;         // auto_increment_en
	localparam int CTL_FRAME_START_DONE_EN = 6;       // frame_start_done_en
	localparam logic [7:0] CTL_RESET = 8'h00;

	// ----------------------------------------------------------------
	// status fields; write one to RELEASE releases the cpu buffer
	// ----------------------------------------------------------------
	localparam int ST_USB_DONE = 0;     // usb_side_done_flag, write 1 clears
	localparam int ST_CPU_DONE = 1;     // cpu_side_done_flag, write 1 clears
	localparam int ST_UBF = 2;          // usb_buffer_full
	localparam int ST_CBF = 3;          // cpu_buffer_full
	localparam int ST_RELEASE = 4;      // write 1: release bit
	localparam int ST_CPU_PAGE = 5;     // page now owned by cpu

	// ----------------------------------------------------------------
	// transfer types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		XFER_CONTROL = 2'h0,
		XFER_ISO = 2'h1,
		XFER_INTR = 2'h2,
		XFER_BULK = 2'h3
	} ubm_xfer_e;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ = 100;
	localparam int FRAME_MS = 1;

endpackage

// ### ubm_mem.sv
/*
 * buffer memory: two pages of 128 bytes, one write port, one read port.
 * assumes callers never write and read the same byte in one cycle.
 */
`timescale 1ns/10ps
module ubm_mem (
	// clock
	input wire logic sys_clk,
	// write port
	input wire logic wrEn,
	input wire logic [ubm_pkg::MEM_AW-1:0] wrAddr,
	input wire logic [7:0] wrData,
	// read port, data one cycle later
	input wire logic [ubm_pkg::MEM_AW-1:0] rdAddr,
	output logic [7:0] rdData
);

	logic [7:0] mem [0:2*ubm_pkg::PAGE_BYTES-1];

	// store and registered fetch
	always_ff @(posedge sys_clk) begin
		if (wrEn) begin
			mem[wrAddr] <= wrData;
		end
		rdData <= mem[rdAddr];
	end

endmodule

// ### ubm_buffer_manager.sv
/*
 * endpoint buffer manager: cpu register port on one side, usb serial
 * engine byte port on the other, two shared pages of buffer memory.
 * assumes the usb engine handles one endpoint at a time, gives start,
 * byte and end strobes, and that the cpu never reads and writes at once.
 */
// Added by the designer: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
module ubm_buffer_manager (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// cpu register port
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	// usb engine: endpoint and frame
	input wire logic [ubm_pkg::EP_W-1:0] usbEp,
	input wire logic usbSof,
	// usb engine: receive (host to device)
	input wire logic usbRxByte,
	input wire logic [7:0] usbRxData,
	input wire logic usbRxEnd,
	input wire logic usbRxOk,
	// usb engine: transmit (device to host)
	input wire logic usbTxStart,
	input wire logic usbTxByte,
	output logic [7:0] usbTxData,
	output logic usbTxReady,
	output logic [6:0] usbTxLen,
	input wire logic usbTxEnd
);

	localparam int N = ubm_pkg::NUM_EP;

	// ----------------------------------------------------------------
	// per endpoint state
	// ----------------------------------------------------------------
	logic [ubm_pkg::EP_W-1:0] epSel_q;
	logic [7:0] ctl_q [N];
	logic [6:0] len_q [N];
	logic [6:0] ofs_q [N];
	logic [N-1:0] usbDone_q, cpuDone_q, ubf_q, cbf_q, cpuPage_q;
	logic [6:0] rxCnt_q, txPtr_q;
	logic rdPending_q, rdMem_q;
	logic [7:0] rdReg_q;

	// type rule: interrupt forced in, endpoint 0 control and always in
	function automatic logic isIn(input logic [7:0] c, input int ep);
		if (ep == 0) begin
			return 1'b1;
		end
		if (c[1:0] == ubm_pkg::XFER_INTR) begin
			return 1'b1;
		end
		return c[ubm_pkg::CTL_DIR_IN];
	endfunction

	// usb page: other page in dual mode, shared page otherwise
	function automatic logic usbPage(input logic [7:0] c, input logic cp);
		return c[ubm_pkg::CTL_DUAL] ? ~cp : c[ubm_pkg::CTL_PAGE];
	endfunction

	// clip a length to the 64-byte packet limit
	function automatic logic [6:0] clipLen(input logic [6:0] l);
		return (l > ubm_pkg::MAX_PKT_LEN) ? ubm_pkg::MAX_PKT_LEN : l;
	endfunction

	// ----------------------------------------------------------------
	// decode of cpu accesses
	// ----------------------------------------------------------------
	logic [7:0] selCtl;
	logic selDual, selPage, selIn, selInc, cpuDataWr, cpuDataRd, relWr;
	logic [6:0] ofsNext;
	logic [6:0] selLen, selOfs;
	assign selCtl = ctl_q[epSel_q];
	assign selLen = len_q[epSel_q];
	assign selOfs = ofs_q[epSel_q];
	assign selDual = selCtl[ubm_pkg::CTL_DUAL];
	assign selPage = selDual ? cpuPage_q[epSel_q] : selCtl[ubm_pkg::CTL_PAGE];
	assign selIn = isIn(selCtl, int'(epSel_q));
	assign selInc = selCtl[ubm_pkg::CTL_INC];
	assign cpuDataWr = regWr && regAddr == ubm_pkg::ADDR_DATA && selIn;
	assign cpuDataRd = regRd && regAddr == ubm_pkg::ADDR_DATA;
	assign relWr = regWr && regAddr == ubm_pkg::ADDR_STAT && regWrData[ubm_pkg::ST_RELEASE];
	assign ofsNext = selOfs + 7'h01;

	// sequential end point reached by this access
	logic seqFull, seqEmpty;
	assign seqFull = cpuDataWr && selInc && ofsNext == selLen;
	assign seqEmpty = cpuDataRd && selInc && ofsNext == selLen;

	// ----------------------------------------------------------------
	// memory addressing
	// ----------------------------------------------------------------
	logic memWr;
	logic [ubm_pkg::MEM_AW-1:0] memWrAddr, memRdAddr;
	logic [7:0] memWrData, memRdData;
	logic usbEpIn;
	logic [7:0] usbCtl;
	assign usbCtl = ctl_q[usbEp];
	assign usbEpIn = isIn(usbCtl, int'(usbEp));

	// usb receive has the write port; a cpu write in the same cycle loses
	always_comb begin
		memWr = 1'b0;
		memWrAddr = '0;
		memWrData = usbRxData;
		if (usbRxByte && !ubf_q[usbEp]) begin
			memWr = 1'b1;
			memWrAddr = {usbPage(usbCtl, cpuPage_q[usbEp]), rxCnt_q};
		end else if (cpuDataWr && !cbf_q[epSel_q]) begin
			memWr = 1'b1;
			memWrAddr = {selPage, selOfs};
			memWrData = regWrData;
		end
	end

	// read port: usb transmit byte fetch, else cpu data read
	always_comb begin
		if (usbTxStart || usbTxByte) begin
			memRdAddr = {usbPage(usbCtl, cpuPage_q[usbEp]),
				usbTxByte ? txPtr_q + 7'h01 : 7'h00};
		end else begin
			memRdAddr = {selPage, selOfs};
		end
	end

	ubm_mem uMem (
		.sys_clk(sys_clk),
		.wrEn(memWr),
		.wrAddr(memWrAddr),
		.wrData(memWrData),
		.rdAddr(memRdAddr),
		.rdData(memRdData)
	);

	// ----------------------------------------------------------------
	// endpoint select and read pending
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			epSel_q <= '0;
			rdPending_q <= 1'b0;
			rdMem_q <= 1'b0;
		end else begin
			rdPending_q <= regRd;
			rdMem_q <= cpuDataRd;
			if (regWr && regAddr == ubm_pkg::ADDR_SEL) begin
				epSel_q <= regWrData[ubm_pkg::EP_W-1:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// usb byte counters
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rxCnt_q <= '0;
			txPtr_q <= '0;
		end else begin
			if (usbRxEnd) begin
				rxCnt_q <= '0;
			end else if (usbRxByte && !ubf_q[usbEp]) begin
				rxCnt_q <= rxCnt_q + 7'h01;
			end
			if (usbTxStart) begin
				txPtr_q <= '0;
			end else if (usbTxByte) begin
				txPtr_q <= txPtr_q + 7'h01;
			end
		end
	end

	// transmit data follows the registered memory read
	assign usbTxData = memRdData;
	assign usbTxLen = len_q[usbEp];

	// usb may read only a full buffer on a device-to-host endpoint
	always_comb begin
		usbTxReady = usbEpIn && ubf_q[usbEp];
	end

	// ----------------------------------------------------------------
	// per endpoint control, length, offset and buffer flags
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int e = 0; e < N; e++) begin
				ctl_q[e] <= ubm_pkg::CTL_RESET;
				len_q[e] <= ubm_pkg::CTRL_DEF_LEN;
				ofs_q[e] <= '0;
			end
			usbDone_q <= '0;
			cpuDone_q <= '0;
			ubf_q <= '0;
			cbf_q <= '0;
			cpuPage_q <= '0;
		end else begin
			for (int e = 0; e < N; e++) begin
				logic cFull, cEmpty, uFull, uEmpty, swap, isSel, isUsb;
				logic dual, epIn;
				cFull = 1'b0;
				cEmpty = 1'b0;
				uFull = 1'b0;
				uEmpty = 1'b0;
				isSel = epSel_q == e[ubm_pkg::EP_W-1:0];
				isUsb = usbEp == e[ubm_pkg::EP_W-1:0];
				dual = ctl_q[e][ubm_pkg::CTL_DUAL];
				epIn = isIn(ctl_q[e], e);
				// cpu register writes
				if (isSel && regWr && regAddr == ubm_pkg::ADDR_CTRL) begin
					ctl_q[e] <= (e == 0) ? {regWrData[7:2], 2'h0} : regWrData;
				end
				if (isSel && regWr && regAddr == ubm_pkg::ADDR_LEN) begin
					len_q[e] <= clipLen(regWrData[6:0]);
				end
				if (isSel && regWr && regAddr == ubm_pkg::ADDR_OFFSET) begin
					ofs_q[e] <= regWrData[6:0];
				end else if (isSel && (cpuDataWr || cpuDataRd) && selInc) begin
					ofs_q[e] <= ofsNext;
				end
				// cpu side full or empty
				if (isSel && epIn && (seqFull || relWr)) begin
					cFull = 1'b1;
					if (relWr && selInc && !seqFull) begin
						len_q[e] <= clipLen(selOfs);
					end
				end
				if (isSel && !epIn && (seqEmpty || relWr)) begin
					cEmpty = 1'b1;
				end
				if (usbSof && ctl_q[e][ubm_pkg::CTL_FRAME_START_DONE_EN] && epIn && !cbf_q[e]) begin
					cFull = 1'b1;
					if (ctl_q[e][ubm_pkg::CTL_INC]) begin
						len_q[e] <= clipLen(ofs_q[e]);
					end
				end
				// usb side events
				if (isUsb && !epIn && usbRxEnd && usbRxOk && !ubf_q[e]) begin
					uFull = 1'b1;
					len_q[e] <= clipLen(rxCnt_q);
				end
				if (isUsb && epIn && usbTxEnd && ubf_q[e]) begin
					uEmpty = 1'b1;
				end
				// flags: hardware set wins over software clear
				if (isSel && regWr && regAddr == ubm_pkg::ADDR_STAT) begin
					if (regWrData[ubm_pkg::ST_USB_DONE]) usbDone_q[e] <= 1'b0;
					if (regWrData[ubm_pkg::ST_CPU_DONE]) cpuDone_q[e] <= 1'b0;
				end
				if (cFull || cEmpty) cpuDone_q[e] <= 1'b1;
				if (uFull || uEmpty) usbDone_q[e] <= 1'b1;
				// buffer ownership
				if (!dual) begin
					// one shared page: direction says who holds it
					if (epIn) begin
						if (cFull) begin
							ubf_q[e] <= 1'b1;
							cbf_q[e] <= 1'b1;
							ofs_q[e] <= '0;
						end else if (uEmpty) begin
							ubf_q[e] <= 1'b0;
							cbf_q[e] <= 1'b0;
						end
					end else begin
						if (uFull) begin
							ubf_q[e] <= 1'b1;
							cbf_q[e] <= 1'b1;
							ofs_q[e] <= '0;
						end else if (cEmpty) begin
							ubf_q[e] <= 1'b0;
							cbf_q[e] <= 1'b0;
							ofs_q[e] <= '0;
						end
					end
				end else if (epIn) begin
					// cpu fills its page while usb drains the other
					logic cb, ub;
					cb = cbf_q[e] | cFull;
					ub = ubf_q[e] & ~uEmpty;
					swap = cb && !ub;
					if (swap) begin
						cpuPage_q[e] <= ~cpuPage_q[e];
						ubf_q[e] <= 1'b1;
						cbf_q[e] <= 1'b0;
						ofs_q[e] <= '0;
					end else begin
						ubf_q[e] <= ub;
						cbf_q[e] <= cb;
					end
				end else begin
					// receive: usb fills, cpu drains
					logic cb, ub;
					cb = cbf_q[e] & ~cEmpty;
					ub = ubf_q[e] | uFull;
					swap = ub && !cb;
					if (swap) begin
						cpuPage_q[e] <= ~cpuPage_q[e];
						ubf_q[e] <= 1'b0;
						cbf_q[e] <= 1'b1;
						ofs_q[e] <= '0;
					end else begin
						ubf_q[e] <= ub;
						cbf_q[e] <= cb;
					end
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// register read data, valid the cycle after the strobe
	// ----------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdReg_q <= '0;
		end else if (regRd) begin
			case (regAddr)
				ubm_pkg::ADDR_SEL: rdReg_q <= {6'h00, epSel_q};
				ubm_pkg::ADDR_OFFSET: rdReg_q <= {1'b0, selOfs};
				ubm_pkg::ADDR_CTRL: rdReg_q <= selCtl;
				ubm_pkg::ADDR_LEN: rdReg_q <= {1'b0, selLen};
				ubm_pkg::ADDR_STAT: rdReg_q <= {2'h0, selPage, 1'b0,
					cbf_q[epSel_q], ubf_q[epSel_q], cpuDone_q[epSel_q],
					usbDone_q[epSel_q]};
				default: rdReg_q <= 8'h00;
			endcase
		end else if (rdPending_q) begin
			rdReg_q <= 8'h00;
		end
	end

	// data register answers straight from the memory output register
	assign regRdData = rdMem_q ? memRdData : rdReg_q;

endmodule

// ### ubm_buffer_manager_asserts.sv
/*
 * port checks for the endpoint buffer manager, bound to its top module.
 * assumes one clock sys_clk and the asynchronous active-low reset rst_b.
 */
`timescale 1ns/10ps
module ubm_buffer_manager_asserts (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// cpu register port
	input wire logic [7:0] regAddr,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	// usb engine
	input wire logic [ubm_pkg::EP_W-1:0] usbEp,
	input wire logic usbSof,
	input wire logic usbRxByte,
	input wire logic usbRxEnd,
	input wire logic usbTxStart,
	input wire logic usbTxByte,
	input wire logic [7:0] usbTxData,
	input wire logic usbTxReady,
	input wire logic [6:0] usbTxLen,
	input wire logic usbTxEnd
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);

	// ------------------------------------------------------------
	// sequences
	// ------------------------------------------------------------
	sequence rd_at(logic [7:0] a);
		regRd && regAddr == a;
	endsequence
	// nothing that could move the fetch address or rewrite the fetched byte
	sequence tx_quiet;
		!usbTxStart && !usbTxByte && !usbTxEnd && !usbSof && !usbRxByte && !usbRxEnd
			&& !regWr && !regRd && $stable(usbEp);
	endsequence

	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	rd_idle_zero_a: assert property (!$past(regRd) |-> regRdData == 8'h00)
		else $error("read data not zero outside a read answer");
	unmapped_read_a: assert property (regRd && regAddr > ubm_pkg::ADDR_STAT
		|=> regRdData == 8'h00)
		else $error("unmapped read gave nonzero data");
	data_read_byte_a: assert property (rd_at(ubm_pkg::ADDR_DATA)
		|=> regRdData == usbTxData)
		else $error("data register read not the fetched byte");
	len_read_max_a: assert property (rd_at(ubm_pkg::ADDR_LEN) |=> regRdData <= 8'h40)
		else $error("length register above 64");
	tx_len_max_a: assert property (usbTxLen <= ubm_pkg::MAX_PKT_LEN)
		else $error("transmit length above 64");
	tx_data_hold_a: assert property (tx_quiet ##1 tx_quiet |=> $stable(usbTxData))
		else $error("transmit byte moved without a fetch");
	ready_rise_a: assert property ($rose(usbTxReady) |-> $past(regWr) || $past(regWr, 2)
		|| $past(usbTxEnd) || $past(usbSof) || $changed(usbEp))
		else $error("transmit ready rose without cause");
	ready_fall_a: assert property ($fell(usbTxReady) |-> $past(usbTxEnd) || $past(regWr)
		|| $changed(usbEp))
		else $error("transmit ready fell without cause");
	len_change_a: assert property ($changed(usbTxLen) |-> $changed(usbEp) || $past(regWr)
		|| $past(regWr, 2) || $past(usbRxEnd) || $past(usbSof) || $past(usbTxEnd))
		else $error("length changed without cause");
endmodule

bind ubm_buffer_manager ubm_buffer_manager_asserts chk_u (.sys_clk, .rst_b, .regAddr, .regWr,
	.regRd, .regRdData, .usbEp, .usbSof, .usbRxByte, .usbRxEnd, .usbTxStart, .usbTxByte,
	.usbTxData, .usbTxReady, .usbTxLen, .usbTxEnd);

// ### ubm_usb_model.sv
/*
 * usb serial engine model: frame start, receive packets, transmit reads.
 * assumes its tasks are called just after a rising edge of sys_clk.
 */
`timescale 1ns/10ps
module ubm_usb_model (
	// clock
	input wire logic sys_clk,
	// strobes toward the manager
	output logic [ubm_pkg::EP_W-1:0] usbEp,
	output logic usbSof,
	output logic usbRxByte,
	output logic [7:0] usbRxData,
	output logic usbRxEnd,
	output logic usbRxOk,
	output logic usbTxStart,
	output logic usbTxByte,
	output logic usbTxEnd,
	// fetched byte
	input wire logic [7:0] usbTxData
);
	logic [7:0] txGot [0:63];

	// idle levels from time zero
	initial begin
		usbEp = '0;
		usbSof = 1'b0;
		usbRxByte = 1'b0;
		usbRxData = 8'h00;
		usbRxEnd = 1'b0;
		usbRxOk = 1'b0;
		usbTxStart = 1'b0;
		usbTxByte = 1'b0;
		usbTxEnd = 1'b0;
	end

	task automatic pick(input logic [ubm_pkg::EP_W-1:0] ep);
		usbEp <= ep;
		@(posedge sys_clk);
	endtask

	task automatic sof();
		usbSof <= 1'b1;
		@(posedge sys_clk);
		usbSof <= 1'b0;
		@(posedge sys_clk);
	endtask

	// bytes then end strobe; data line inverted once released
	task automatic rx_send(input int n, input logic [7:0] base, input logic ok);
		for (int i = 0; i < n; i++) begin
			usbRxByte <= 1'b1;
			usbRxData <= base + 8'(i);
			@(posedge sys_clk);
		end
		usbRxByte <= 1'b0;
		usbRxData <= ~usbRxData;
		usbRxEnd <= 1'b1;
		usbRxOk <= ok;
		@(posedge sys_clk);
		usbRxEnd <= 1'b0;
		usbRxOk <= 1'b0;
		@(posedge sys_clk);
	endtask

	// start, one byte pulse per byte, end once the buffer is read
	task automatic tx_read(input int n);
		usbTxStart <= 1'b1;
		@(posedge sys_clk);
		usbTxStart <= 1'b0;
		for (int i = 0; i < n; i++) begin
			usbTxByte <= 1'b1;
			@(negedge sys_clk);
			txGot[i] = usbTxData;
			@(posedge sys_clk);
		end
		usbTxByte <= 1'b0;
		usbTxEnd <= 1'b1;
		@(posedge sys_clk);
		usbTxEnd <= 1'b0;
		@(posedge sys_clk);
	endtask
endmodule

// ### tb_top.sv
/*
 * self-checking bench for the buffer manager: cpu side driven here,
 * usb side by the engine model.
 * assumes the package, memory, manager, checker and model are compiled first.
 */
`timescale 1ns/10ps
module tb_top;
	logic sys_clk = 1'b0;
	logic rst_b;
	logic [7:0] regAddr, regWrData;
	logic regWr, regRd;
	logic [7:0] regRdData, usbRxData, usbTxData, rd;
	logic [ubm_pkg::EP_W-1:0] usbEp;
	logic usbSof, usbRxByte, usbRxEnd, usbRxOk, usbTxStart, usbTxByte, usbTxEnd, usbTxReady;
	logic [6:0] usbTxLen;
	logic pg;
	int compares = 0;
	int miscompares = 0;

	always #5 sys_clk = ~sys_clk;

	ubm_buffer_manager dut_u (.sys_clk, .rst_b, .regAddr, .regWrData, .regWr, .regRd,
		.regRdData, .usbEp, .usbSof, .usbRxByte, .usbRxData, .usbRxEnd, .usbRxOk, .usbTxStart,
		.usbTxByte, .usbTxData, .usbTxReady, .usbTxLen, .usbTxEnd);
	ubm_usb_model usb_u (.sys_clk, .usbEp, .usbSof, .usbRxByte, .usbRxData, .usbRxEnd,
		.usbRxOk, .usbTxStart, .usbTxByte, .usbTxEnd, .usbTxData);

	// ------------------------------------------------------------
	// bus cycles and compares
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
		@(posedge sys_clk); // idle edge: the strobe is never set twice in one step
	endtask
	task automatic rdr(input logic [7:0] a);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		@(negedge sys_clk);
		rd = regRdData;
		@(posedge sys_clk);
	endtask
	task automatic reg_is(input logic [7:0] a, input logic [7:0] exp);
		rdr(a);
		chk("register", exp, rd);
	endtask
	task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
		rdr(ubm_pkg::ADDR_STAT);
		chk("status", exp, rd & mask);
	endtask
	task automatic tx_is(input logic rdy, input logic [6:0] len);
		@(negedge sys_clk);
		chk("tx ready", {7'h00, rdy}, {7'h00, usbTxReady});
		chk("tx length", {1'b0, len}, {1'b0, usbTxLen});
		@(posedge sys_clk);
	endtask
	task automatic tx_bytes(input logic [7:0] base, input int n);
		for (int i = 0; i < n; i++) chk("tx byte", base + 8'(i), usb_u.txGot[i]);
	endtask
	task automatic fill(input logic [7:0] base, input int n);
		for (int i = 0; i < n; i++) wr(ubm_pkg::ADDR_DATA, base + 8'(i));
	endtask

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		wr(ubm_pkg::ADDR_SEL, 8'h00);
		reg_is(ubm_pkg::ADDR_LEN, 8'h08);
		reg_is(ubm_pkg::ADDR_CTRL, 8'h00);
		stat(8'hFF, 8'h00);
		reg_is(8'h07, 8'h00);
		wr(ubm_pkg::ADDR_LEN, 8'h50);
		reg_is(ubm_pkg::ADDR_LEN, 8'h40);
		wr(ubm_pkg::ADDR_LEN, 8'h08);
		$display("test reset done");
	endtask
	// interrupt IN, single page, sequential fill to the length
	task automatic t_single_in();
		wr(ubm_pkg::ADDR_SEL, 8'h01);
		wr(ubm_pkg::ADDR_CTRL, 8'h26);
		wr(ubm_pkg::ADDR_LEN, 8'h04);
		wr(ubm_pkg::ADDR_OFFSET, 8'h00);
		fill(8'hA0, 4);
		stat(8'h02, 8'h02);
		usb_u.pick(2'h1);
		tx_is(1'b1, 7'h04);
		usb_u.tx_read(4);
		tx_bytes(8'hA0, 4);
		tx_is(1'b0, 7'h04);
		stat(8'h01, 8'h01);
		reg_is(ubm_pkg::ADDR_OFFSET, 8'h00);
		$display("test single in done");
	endtask
	// bulk IN, dual pages, early release and writes while the usb page waits to be read
	task automatic t_dual_release();
		wr(ubm_pkg::ADDR_SEL, 8'h02);
		wr(ubm_pkg::ADDR_CTRL, 8'h2F);
		wr(ubm_pkg::ADDR_LEN, 8'h10);
		wr(ubm_pkg::ADDR_OFFSET, 8'h00);
		rdr(ubm_pkg::ADDR_STAT);
		pg = rd[ubm_pkg::ST_CPU_PAGE];
		fill(8'hB0, 3);
		wr(ubm_pkg::ADDR_STAT, 8'h10);
		stat(8'h24, {2'h0, ~pg, 5'h04});
		reg_is(ubm_pkg::ADDR_LEN, 8'h03);
		usb_u.pick(2'h2);
		tx_is(1'b1, 7'h03);
		fill(8'hC0, 2);
		wr(ubm_pkg::ADDR_STAT, 8'h10);
		usb_u.tx_read(3);
		tx_bytes(8'hB0, 3);
		tx_is(1'b1, 7'h02);
		usb_u.tx_read(2);
		tx_bytes(8'hC0, 2);
		$display("test dual release done");
	endtask
	// isochronous OUT: bad packet, good packet, cpu drains it
	task automatic t_out_rx();
		wr(ubm_pkg::ADDR_SEL, 8'h03);
		wr(ubm_pkg::ADDR_CTRL, 8'h31);
		usb_u.pick(2'h3);
		usb_u.rx_send(2, 8'h50, 1'b0);
		stat(8'h01, 8'h00);
		usb_u.rx_send(5, 8'h60, 1'b1);
		stat(8'h01, 8'h01);
		reg_is(ubm_pkg::ADDR_LEN, 8'h05);
		wr(ubm_pkg::ADDR_OFFSET, 8'h00);
		for (int i = 0; i < 4; i++) begin
			rdr(ubm_pkg::ADDR_DATA);
			chk("rx byte", 8'h60 + 8'(i), rd);
		end
		stat(8'h02, 8'h00);
		rdr(ubm_pkg::ADDR_DATA);
		chk("rx byte", 8'h64, rd);
		stat(8'h02, 8'h02);
		$display("test out receive done");
	endtask
	// isochronous OUT, dual pages: cpu release with usb full swaps at once
	task automatic t_dual_out();
		wr(ubm_pkg::ADDR_CTRL, 8'h29);
		usb_u.rx_send(3, 8'h70, 1'b1);
		stat(8'h2C, 8'h28);
		usb_u.rx_send(2, 8'h80, 1'b1);
		stat(8'h2C, 8'h2C);
		wr(ubm_pkg::ADDR_STAT, 8'h10);
		stat(8'h2C, 8'h08);
		rdr(ubm_pkg::ADDR_DATA);
		chk("rx byte", 8'h80, rd);
		$display("test dual out done");
	endtask
	// frame start closes the buffer only when enabled
	task automatic t_frame_done();
		wr(ubm_pkg::ADDR_SEL, 8'h00);
		wr(ubm_pkg::ADDR_CTRL, 8'h20);
		wr(ubm_pkg::ADDR_OFFSET, 8'h00);
		fill(8'h11, 2);
		usb_u.sof();
		stat(8'h02, 8'h00);
		wr(ubm_pkg::ADDR_CTRL, 8'h60);
		usb_u.sof();
		stat(8'h02, 8'h02);
		reg_is(ubm_pkg::ADDR_LEN, 8'h02);
		$display("test frame done done");
	endtask

	// ------------------------------------------------------------
	// run control
	// ------------------------------------------------------------
	task automatic results();
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	initial begin
		rst_b = 1'b0;
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
		repeat (12) @(posedge sys_clk);
		rst_b <= 1'b1;
		@(posedge sys_clk);
		t_reset();
		t_single_in();
		t_dual_release();
		t_out_rx();
		t_dual_out();
		t_frame_done();
		results();
	end
	// watchdog well beyond the roughly 185 cycles the tests need
	initial begin
		repeat (5000) @(posedge sys_clk);
		miscompares++;
		results();
	end
endmodule
